/* core/acsp_pkg.sv */
// Package of constants for the amplifier control serial port.
`default_nettype none
package acsp_pkg;

  // ****************************************
  // Address and command layout
  // ****************************************
  localparam logic [6:0] ADDR_HIGH_BITS = 7'h36;
  localparam int ADDR_STRAP_POS = 1;
  localparam logic [2:0] DEST_MODE = 3'h0;
  localparam logic [2:0] DEST_VOLUME = 3'h4;
  localparam int DEST_POS = 5;
  localparam int HEADPHONE_POS = 4;
  localparam int GAIN_POS = 3;
  localparam int MODE_POS = 2;
  localparam int MUTE_POS = 1;
  localparam int SHDN_POS = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [4:0] MODE_RESET = 5'h00;
  localparam logic [4:0] VOLUME_RESET = 5'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SYS_CLK_HZ = 20000000;
  localparam int MAX_SCL_HZ = 400000;
  localparam int SCL_HALF_CYCLES = SYS_CLK_HZ / (2 * MAX_SCL_HZ);
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_DATA, ST_DATA_ACK, ST_IGNORE
  } acsp_state_t;

endpackage : acsp_pkg
`default_nettype wire

/* core/acsp_sync.sv */
// Two flip-flop synchroniser for the pin inputs.
`timescale 1ns/10ps
`default_nettype none
module acsp_sync
  import acsp_pkg::*;
#(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Pins
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinSync
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  // Reset to all ones because the bus idles released high.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stage1_r <= '1;
      stage2_r <= '1;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
    end
  end

  assign pinSync = stage2_r;

endmodule : acsp_sync
`default_nettype wire

/* core/acsp_slave.sv */
// Write-only two-wire control port of the amplifier.
`timescale 1ns/10ps
`default_nettype none

module acsp_slave
  import acsp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Two-wire bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  // Strap
  input wire logic address_select_strap,
  // Control settings
  output logic headphone_select_bit,
  output logic gainExternal,
  output logic volumeAdjustable,
  output logic muteOn,
  output logic deviceActive,
  output logic [4:0] volume,
  // Status
  output logic busy,
  output logic addrMatched
);

  // ****************************************
  // Pin sampling
  // ****************************************
  logic [2:0] pinSync;
  logic sclS, sdaS, strapS;

  acsp_sync #(.WIDTH(3)) uSync (
    .clk_sys(clk_sys),
    .srst(srst),
    .pinIn({sclIn, sdaIn, address_select_strap}),
    .pinSync(pinSync)
  );

  assign sclS = pinSync[2];
  assign sdaS = pinSync[1];
  assign strapS = pinSync[0];

  logic sclPrev_r, sdaPrev_r;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= sclS;
      sdaPrev_r <= sdaS;
    end
  end

  logic sclRise, sclFall, startSeen, stopSeen;
  assign sclRise = sclS & ~sclPrev_r;
  assign sclFall = ~sclS & sclPrev_r;
  assign startSeen = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
  assign stopSeen = sclS & sclPrev_r & ~sdaPrev_r & sdaS;

  // ****************************************
  // Receiver state
  // ****************************************
  acsp_state_t state_r, state_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [3:0] bitCnt_r, bitCnt_nxt;
  logic ackDrive_r, ackDrive_nxt;
  logic sawRise_r, sawRise_nxt;
  logic matched_r, matched_nxt;
  logic [4:0] mode_r, mode_nxt;
  logic [4:0] vol_r, vol_nxt;
  logic [7:0] ownAddr;

  // The low six bits of the constant are the fixed top of the address byte.
  assign ownAddr = {ADDR_HIGH_BITS[5:0], strapS, 1'b0};

  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    bitCnt_nxt = bitCnt_r;
    ackDrive_nxt = ackDrive_r;
    sawRise_nxt = sawRise_r;
    matched_nxt = matched_r;
    mode_nxt = mode_r;
    vol_nxt = vol_r;
    if (startSeen) begin
      // A repeated start mid-byte just restarts address reception.
      state_nxt = ST_ADDR;
      bitCnt_nxt = 4'h0;
      ackDrive_nxt = 1'b0;
      matched_nxt = 1'b0;
    end else if (stopSeen) begin
      state_nxt = ST_IDLE;
      ackDrive_nxt = 1'b0;
      matched_nxt = 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE, ST_IGNORE: begin
          ackDrive_nxt = 1'b0;
        end
        ST_ADDR, ST_DATA: begin
          if (sclRise) begin
            shift_nxt = {shift_r[6:0], sdaS};
            bitCnt_nxt = bitCnt_r + 4'h1;
          end
          if (sclFall && bitCnt_r == BITS_PER_BYTE) begin
            bitCnt_nxt = 4'h0;
            sawRise_nxt = 1'b0;
            if (state_r == ST_ADDR) begin
              if (shift_r == ownAddr) begin
                state_nxt = ST_ADDR_ACK;
                ackDrive_nxt = 1'b1;
                matched_nxt = 1'b1;
              end else begin
                state_nxt = ST_IGNORE;
              end
            end else begin
              state_nxt = ST_DATA_ACK;
              ackDrive_nxt = 1'b1;
              if (shift_r[7:DEST_POS] == DEST_MODE) begin
                mode_nxt = shift_r[4:0];
              end else if (shift_r[7:DEST_POS] == DEST_VOLUME) begin
                vol_nxt = shift_r[4:0];
              end
            end
          end
        end
        ST_ADDR_ACK, ST_DATA_ACK: begin
          if (sclRise) begin
            sawRise_nxt = 1'b1;
          end
          // Release only after the acknowledge pulse has finished.
          if (sclFall && sawRise_r) begin
            ackDrive_nxt = 1'b0;
            state_nxt = ST_DATA;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= ST_IDLE;
      shift_r <= 8'h00;
      bitCnt_r <= 4'h0;
      ackDrive_r <= 1'b0;
      sawRise_r <= 1'b0;
      matched_r <= 1'b0;
      mode_r <= MODE_RESET;
      vol_r <= VOLUME_RESET;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      bitCnt_r <= bitCnt_nxt;
      ackDrive_r <= ackDrive_nxt;
      sawRise_r <= sawRise_nxt;
      matched_r <= matched_nxt;
      mode_r <= mode_nxt;
      vol_r <= vol_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // The data pin is only ever pulled low; the clock is never driven.
  assign sdaOut = 1'b0;
  assign sdaOe_n = ~ackDrive_r;
  assign headphone_select_bit = mode_r[HEADPHONE_POS];
  assign gainExternal = mode_r[GAIN_POS];
  assign volumeAdjustable = mode_r[MODE_POS];
  assign muteOn = mode_r[MUTE_POS];
  assign deviceActive = mode_r[SHDN_POS];
  assign volume = vol_r;
  assign busy = (state_r != ST_IDLE);
  assign addrMatched = matched_r;

  // ****************************************
  // Checks
  // ****************************************
  a_start_goes_addr: assert property (
    @(posedge clk_sys) disable iff (srst)
    startSeen |=> state_r == ST_ADDR && bitCnt_r == 4'h0)
    else $error("Start did not begin address reception.");
  a_stop_goes_idle: assert property (
    @(posedge clk_sys) disable iff (srst)
    stopSeen |=> state_r == ST_IDLE && sdaOe_n)
    else $error("Stop did not return to idle.");
  a_match_acks: assert property (
    @(posedge clk_sys) disable iff (srst)
    (state_r == ST_ADDR && sclFall && bitCnt_r == 4'h8 &&
     shift_r == ownAddr && !startSeen && !stopSeen) |=> !sdaOe_n)
    else $error("Matching address not acknowledged.");
  a_mismatch_quiet: assert property (
    @(posedge clk_sys) disable iff (srst)
    (state_r == ST_ADDR && sclFall && bitCnt_r == 4'h8 &&
     shift_r != ownAddr && !startSeen && !stopSeen)
    |=> state_r == ST_IGNORE && sdaOe_n)
    else $error("Mismatched address not ignored.");
  a_ignore_released: assert property (
    @(posedge clk_sys) disable iff (srst)
    state_r == ST_IGNORE |-> sdaOe_n)
    else $error("Data driven while ignoring.");
  a_data_acks: assert property (
    @(posedge clk_sys) disable iff (srst)
    (state_r == ST_DATA && sclFall && bitCnt_r == 4'h8 &&
     !startSeen && !stopSeen) |=> state_r == ST_DATA_ACK && !sdaOe_n)
    else $error("Data byte not acknowledged.");
  a_mode_load: assert property (
    @(posedge clk_sys) disable iff (srst)
    (state_r == ST_DATA && sclFall && bitCnt_r == 4'h8 &&
     shift_r[7:5] == 3'h0 && !startSeen && !stopSeen)
    |=> {headphone_select_bit, gainExternal, volumeAdjustable, muteOn,
         deviceActive} == $past(shift_r[4:0]))
    else $error("Mode byte not loaded.");
  a_settings_hold: assert property (
    @(posedge clk_sys) disable iff (srst)
    (startSeen || stopSeen) |=> $stable(volume) && $stable(muteOn))
    else $error("Setting changed on start or stop.");
  a_never_high: assert property (
    @(posedge clk_sys) disable iff (srst)
    !sdaOe_n |-> sdaOut == 1'b0)
    else $error("Data pin driven high.");
  a_drive_in_ack: assert property (
    @(posedge clk_sys) disable iff (srst)
    !sdaOe_n |-> (state_r == ST_ADDR_ACK || state_r == ST_DATA_ACK))
    else $error("Data pulled low outside an acknowledge.");

endmodule : acsp_slave
`default_nettype wire

/* tb/acsp_host.sv */
// Host master model that drives the two-wire bus into the port.
`timescale 1ns/10ps
`default_nettype none
module acsp_host (
  // Clock
  input wire logic clk_sys,
  // Device side of the data pin
  input wire logic sdaOut,
  input wire logic sdaOe_n,
  // Bus wires
  output logic scl,
  output logic sdaWire
);
  // ****************************************
  // Bus wires and bit timing
  // ****************************************
  logic sdaDrv;
  logic inFrame;
  // The pull-up wins unless a party pulls low.
  assign sdaWire = sdaDrv & (sdaOe_n | sdaOut);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
    inFrame = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  // Five cycles low and three high give the 400 ns bit period.
  task automatic clock_bit(input logic b, output logic seen);
    scl = 1'b0;
    tick(1);
    sdaDrv = b;
    tick(4);
    scl = 1'b1;
    tick(2);
    seen = sdaWire;
    tick(1);
  endtask : clock_bit
  // Inside a frame the wire is first brought back high for a restart.
  task automatic start_cond();
    if (inFrame) begin
      scl = 1'b0;
      tick(1);
      sdaDrv = 1'b1;
      tick(4);
      scl = 1'b1;
      tick(3);
    end
    sdaDrv = 1'b0;
    inFrame = 1'b1;
    tick(4);
  endtask : start_cond
  task automatic stop_cond();
    scl = 1'b0;
    tick(1);
    sdaDrv = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(3);
    sdaDrv = 1'b1;
    inFrame = 1'b0;
    tick(4);
  endtask : stop_cond
  task automatic send_bits(input logic [7:0] b, input int n);
    logic seen;
    for (int i = 7; i > 7 - n; i--) begin
      clock_bit(b[i], seen);
    end
  endtask : send_bits
  // Returns the wire level seen in the acknowledge pulse.
  task automatic send_byte(input logic [7:0] b, output logic ackLevel);
    send_bits(b, 8);
    clock_bit(1'b1, ackLevel);
  endtask : send_byte
endmodule : acsp_host
`default_nettype wire

/* tb/i2c_control_write_slave_tb.sv */
// Testbench of the amplifier control serial port.
`timescale 1ns/10ps
`default_nettype none
module i2c_control_write_slave_tb;
  // ****************************************
  // Design, host model and checks
  // ****************************************
  logic clk_sys, srst, strap, scl, sdaWire, sdaOut, sdaOe_n;
  logic phones, gain, volAdj, mute, active, busy, addrMatched;
  logic [4:0] volume;
  logic [4:0] settings;
  int mismatches = 0;
  int testsRun = 0;
  assign settings = {phones, gain, volAdj, mute, active};
  acsp_slave dut (.clk_sys(clk_sys), .srst(srst), .sclIn(scl),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
    .address_select_strap(strap), .headphone_select_bit(phones),
    .gainExternal(gain), .volumeAdjustable(volAdj), .muteOn(mute),
    .deviceActive(active), .volume(volume), .busy(busy),
    .addrMatched(addrMatched));
  acsp_host host (.clk_sys(clk_sys), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
    .scl(scl), .sdaWire(sdaWire));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic tally_and_finish();
    if (mismatches == 0 && testsRun > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    testsRun++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic put(input logic [7:0] b, input logic expLevel);
    logic lvl;
    host.send_byte(b, lvl);
    check({4'h0, lvl}, {4'h0, expLevel});
  endtask : put
  // A receiver stuck busy would hang every later frame, so stop here.
  task automatic end_frame();
    int n;
    n = 0;
    host.stop_cond();
    while (busy !== 1'b0 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    check({4'h0, busy}, 5'h00);
    check({4'h0, sdaOe_n}, 5'h01);
    if (busy !== 1'b0) begin
      tally_and_finish();
    end
  endtask : end_frame
  initial begin
    srst = 1'b1;
    strap = 1'b0;
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    repeat (3) @(negedge clk_sys);
    check(settings, 5'h00);
    check(volume, 5'h00);
    check({4'h0, sdaOe_n}, 5'h01);
    host.start_cond();
    put(8'hd8, 1'b0);
    check({4'h0, addrMatched}, 5'h01);
    put(8'h15, 1'b0);
    put(8'h96, 1'b0);
    put(8'h3f, 1'b0);
    end_frame();
    check(settings, 5'h15);
    check(volume, 5'h16);
    host.start_cond();
    put(8'hda, 1'b1);
    put(8'h0a, 1'b1);
    end_frame();
    check(settings, 5'h15);
    strap = 1'b1;
    repeat (4) @(negedge clk_sys);
    host.start_cond();
    put(8'hd8, 1'b1);
    host.start_cond();
    put(8'hda, 1'b0);
    put(8'h0a, 1'b0);
    host.send_bits(8'h9f, 4);
    host.start_cond();
    put(8'hda, 1'b0);
    put(8'h81, 1'b0);
    host.send_bits(8'h00, 5);
    end_frame();
    check(settings, 5'h0a);
    check(volume, 5'h01);
    check({4'h0, addrMatched}, 5'h00);
    tally_and_finish();
  end
endmodule : i2c_control_write_slave_tb
`default_nettype wire
